// file: hw/inval_defines.svh
// Purpose: Offsets, field positions and reset values of the invalidation engine
// Assumes: Included by bare name wherever the register map is needed
// Notes:   Definitions only; no logic lives here
`ifndef INVAL_DEFINES_SVH
`define INVAL_DEFINES_SVH

// ***************************************************************
// Register offsets (byte addresses, one word each)
// ***************************************************************
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_ERR_OP        8'h08
`define REG_INFLIGHT      8'h0C
`define REG_CFG_MAP       8'h10
`define REG_TLB_MAP       8'h14
`define REG_CAPS          8'h18

// ***************************************************************
// Field positions and reset values
// ***************************************************************
`define CTRL_VMW_BIT      0
`define STAT_ILL_BIT      0
`define STAT_WAIT_BIT     1
`define CAPS_ASID_BIT     0
`define CAPS_VMID_BIT     1
`define CTRL_RESET        1'h0
`define RANGE_ALL         5'h1F
`define NARROW_ID_HI      15
`define NARROW_ID_LO      8

`endif

// file: hw/inval_engine.sv
// Purpose: Configuration and translation-cache invalidation with sync completion
// Assumes: Command port, fills and transaction events all on REF_CLK
// Notes:   Every invalidation finishes in the edge that takes it
`timescale 1ns/100ps
`default_nettype none
`include "inval_defines.svh"
module inval_engine
   import inval_pkg::*;
#(
   parameter int          CFG_ENTRIES = 16,
   parameter int          TLB_ENTRIES = 16,
   parameter int          SID_W       = 32,
   parameter int          VA_W        = 36,
   parameter int          CNT_W       = 8,
   parameter int          WILD_BITS   = 4,
   parameter logic        WIDE_ASID   = 1'b1,
   parameter logic        WIDE_VMID   = 1'b1
)(
   // Clock and reset
   input  wire logic                           REF_CLK,
   input  wire logic                           ARST_N,
   // Register port
   input  wire logic [7:0]                     REG_ADDR,
   input  wire logic [31:0]                    REG_WDATA,
   input  wire logic                           REG_WR,
   input  wire logic                           REG_RD,
   output logic      [31:0]                    REG_RDATA,
   // Command port
   input  wire logic                           CMD_VALID,
   output logic                                CMD_READY,
   input  wire logic [3:0]                     CMD_OP,
   input  wire logic                           CMD_NS_QUEUE,
   input  wire logic                           CMD_SEC,
   input  wire logic [SID_W-1:0]               CMD_SID,
   input  wire logic [4:0]                     CMD_RANGE,
   input  wire logic                           CMD_LEAF,
   input  wire logic [15:0]                    CMD_ASID,
   input  wire logic [15:0]                    CMD_VMID,
   input  wire logic [VA_W-1:0]                CMD_VA,
   // Command results
   output logic                                SYNC_DONE,
   output logic                                ILLEGAL_CMD,
   // Configuration cache fill
   input  wire logic                           CFG_FILL,
   input  wire logic [$clog2(CFG_ENTRIES)-1:0] CFG_FILL_IDX,
   input  wire logic                           CFG_FILL_SEC,
   input  wire logic [SID_W-1:0]               CFG_FILL_SID,
   input  wire logic [2:0]                     CFG_FILL_KIND,
   // Translation cache fill
   input  wire logic                           TLB_FILL,
   input  wire logic [$clog2(TLB_ENTRIES)-1:0] TLB_FILL_IDX,
   input  wire logic                           TLB_FILL_SEC,
   input  wire logic [15:0]                    TLB_FILL_VMID,
   input  wire logic [15:0]                    TLB_FILL_ASID,
   input  wire logic [VA_W-1:0]                TLB_FILL_VA,
   input  wire logic [5:0]                     TLB_FILL_SIZE,
   input  wire logic                           TLB_FILL_LEAF,
   // Transaction tracking
   input  wire logic                           XLAT_START,
   input  wire logic                           XLAT_DONE,
   input  wire logic                           XLAT_DONE_EPOCH,
   output logic                                XLAT_EPOCH
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   seq_state_t               state_r;
   seq_state_t               state_nxt;
   logic                     ctrl_vmw_r;
   logic                     ill_r;
   logic [3:0]               err_op_r;
   logic                     epoch_r;
   logic [CNT_W-1:0]         cnt_r [2];
   logic [CNT_W-1:0]         old_cnt;
   logic [CFG_ENTRIES-1:0]   cfg_valid_r;
   logic [CFG_ENTRIES-1:0]   cfg_sec_r;
   logic [SID_W-1:0]         cfg_sid_r  [CFG_ENTRIES];
   logic [2:0]               cfg_kind_r [CFG_ENTRIES];
   logic                     op_known;
   logic                     op_cfg;
   logic                     op_tlb;
   logic                     legal;
   logic                     take;
   logic                     exec;
   logic                     range_all;
   logic [SID_W-1:0]         sid_mask;
   logic [7:0]               kind_sel;
   logic                     uses_asid;
   logic                     uses_vmid;
   logic                     id_skip;
   tlb_mode_t                mode;

   tlb_if #(.ENTRIES(TLB_ENTRIES), .VA_W(VA_W)) tif ();

   // ***************************************************************
   // Command decode
   // ***************************************************************

   // Classify the opcode and its scope
   always_comb
   begin
      op_known  = 1'b1;
      op_cfg    = 1'b0;
      op_tlb    = 1'b0;
      uses_asid = 1'b0;
      uses_vmid = 1'b0;
      kind_sel  = 8'h00;
      mode      = TM_ALL;
      unique case (CMD_OP)
         OP_CFG_EVERY, OP_STE, OP_STE_RANGE:
         begin
            op_cfg   = 1'b1;
            kind_sel = 8'h1F;
         end
         OP_CD:
         begin
            op_cfg   = 1'b1;
            kind_sel = CMD_LEAF ? 8'h04 : 8'h0C;
         end
         OP_CD_EVERY:
         begin
            op_cfg   = 1'b1;
            kind_sel = 8'h0C;
         end
         OP_TLB_ALL:
         begin
            op_tlb = 1'b1;
         end
         OP_TLB_VMID:
         begin
            op_tlb    = 1'b1;
            uses_vmid = 1'b1;
            mode      = TM_VMID;
         end
         OP_TLB_ASID:
         begin
            op_tlb    = 1'b1;
            uses_vmid = 1'b1;
            uses_asid = 1'b1;
            mode      = TM_ASID;
         end
         OP_TLB_VA:
         begin
            op_tlb    = 1'b1;
            uses_vmid = 1'b1;
            uses_asid = 1'b1;
            mode      = TM_VA;
         end
         OP_SYNC:
         begin
            op_known = 1'b1;
         end
         default:
         begin
            op_known = 1'b0;
         end
      endcase
   end

   // Secure scope requested from the non-secure queue is refused
   assign legal = op_known && !((op_cfg || op_tlb) && CMD_NS_QUEUE && CMD_SEC);

   // Global form is range 31; stream operand then plays no part
   assign range_all = (CMD_OP == OP_CFG_EVERY) ||
                      ((CMD_OP == OP_STE_RANGE) && (CMD_RANGE == `RANGE_ALL));
   assign sid_mask  = (CMD_OP == OP_STE_RANGE) ? ({SID_W{1'b1}} << (6'(CMD_RANGE) + 6'h01))
                                               : {SID_W{1'b1}};

   // Narrow identifiers with a nonzero upper byte invalidate nothing
   assign id_skip = (uses_asid && !WIDE_ASID && (CMD_ASID[`NARROW_ID_HI:`NARROW_ID_LO] != 8'h00)) ||
                    (uses_vmid && !WIDE_VMID && (CMD_VMID[`NARROW_ID_HI:`NARROW_ID_LO] != 8'h00));

   // ***************************************************************
   // Sequencer
   // ***************************************************************

   // Fills hold commands off in ST_IDLE only; in ST_WAIT readiness ignores fills and follows the old-epoch count
   always_comb
   begin
      CMD_READY = 1'b0;
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:
         begin
            CMD_READY = !CFG_FILL && !TLB_FILL && !(CMD_OP == OP_SYNC);
            if (CMD_VALID && (CMD_OP == OP_SYNC))
            begin
               state_nxt = ST_WAIT;
            end
         end
         ST_WAIT:
         begin
            CMD_READY = (old_cnt == '0);
            if (CMD_VALID && CMD_READY)
            begin
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   assign take = CMD_VALID && CMD_READY;
   assign exec = take && legal && (CMD_OP != OP_SYNC);

   // Sequencer state
   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         state_r <= ST_IDLE;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // Result pulses, one cycle after the command is taken
   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         SYNC_DONE   <= 1'b0;
         ILLEGAL_CMD <= 1'b0;
      end
      else
      begin
         SYNC_DONE   <= take && (state_r == ST_WAIT);
         ILLEGAL_CMD <= take && !legal;
      end
   end

   // ***************************************************************
   // Transaction epochs
   // ***************************************************************

   // Sync flips the epoch; the old epoch holds every transaction that
   // could have used a structure invalidated before the sync
   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         epoch_r <= 1'b0;
      end
      else if ((state_r == ST_IDLE) && CMD_VALID && (CMD_OP == OP_SYNC))
      begin
         epoch_r <= ~epoch_r;
      end
   end

   assign XLAT_EPOCH = epoch_r;
   assign old_cnt    = cnt_r[~epoch_r];

   // Outstanding transactions per epoch; stalled ones just stay counted
   genvar e;
   generate
      for (e = 0; e < 2; e++)
      begin : g_epoch
         logic inc;
         logic dec;
         assign inc = XLAT_START && (epoch_r == e);
         assign dec = XLAT_DONE && (XLAT_DONE_EPOCH == e);
         always_ff @(posedge REF_CLK or negedge ARST_N)
         begin
            if (!ARST_N)
            begin
               cnt_r[e] <= '0;
            end
            else if (inc && !dec)
            begin
               cnt_r[e] <= cnt_r[e] + CNT_W'(1);
            end
            else if (dec && !inc)
            begin
               cnt_r[e] <= cnt_r[e] - CNT_W'(1);
            end
         end
      end
   endgenerate

   // ***************************************************************
   // Configuration cache
   // ***************************************************************

   // Entries removed in one edge; a later lookup misses and refetches
   genvar c;
   generate
      for (c = 0; c < CFG_ENTRIES; c++)
      begin : g_cfg
         logic hit;
         assign hit = cfg_valid_r[c] && (cfg_sec_r[c] == CMD_SEC) && kind_sel[cfg_kind_r[c]] &&
                      (range_all || (((cfg_sid_r[c] ^ CMD_SID) & sid_mask) == '0));
         always_ff @(posedge REF_CLK or negedge ARST_N)
         begin
            if (!ARST_N)
            begin
               cfg_valid_r[c] <= 1'b0;
               cfg_sec_r[c]   <= 1'b0;
               cfg_sid_r[c]   <= '0;
               cfg_kind_r[c]  <= KIND_STE;
            end
            else if (CFG_FILL && (CFG_FILL_IDX == c))
            begin
               cfg_valid_r[c] <= 1'b1;
               cfg_sec_r[c]   <= CFG_FILL_SEC;
               cfg_sid_r[c]   <= CFG_FILL_SID;
               cfg_kind_r[c]  <= CFG_FILL_KIND;
            end
            else if (exec && op_cfg && hit)
            begin
               cfg_valid_r[c] <= 1'b0;
            end
         end
      end
   endgenerate

   // ***************************************************************
   // Translation cache
   // ***************************************************************

   // Invalidation reaches only the local store, never the interconnect
   assign tif.inv       = exec && op_tlb && !id_skip;
   assign tif.inv_mode  = mode;
   assign tif.inv_sec   = CMD_SEC;
   assign tif.inv_vmid  = CMD_VMID;
   assign tif.inv_asid  = CMD_ASID;
   assign tif.inv_va    = CMD_VA;
   assign tif.inv_leaf  = CMD_LEAF;
   assign tif.vmw_en    = ctrl_vmw_r;
   assign tif.fill      = TLB_FILL;
   assign tif.fill_idx  = TLB_FILL_IDX;
   assign tif.fill_sec  = TLB_FILL_SEC;
   assign tif.fill_vmid = TLB_FILL_VMID;
   assign tif.fill_asid = TLB_FILL_ASID;
   assign tif.fill_va   = TLB_FILL_VA;
   assign tif.fill_size = TLB_FILL_SIZE;
   assign tif.fill_leaf = TLB_FILL_LEAF;

   tlb_store #(
      .ENTRIES   (TLB_ENTRIES),
      .VA_W      (VA_W),
      .WILD_BITS (WILD_BITS)
   ) u_tlb (
      .clk    (REF_CLK),
      .arst_n (ARST_N),
      .tif    (tif.store)
   );

   // ***************************************************************
   // Registers
   // ***************************************************************

   // Control word steers wildcard matching
   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         ctrl_vmw_r <= `CTRL_RESET;
      end
      else if (REG_WR && (REG_ADDR == `REG_CTRL))
      begin
         ctrl_vmw_r <= REG_WDATA[`CTRL_VMW_BIT];
      end
   end

   // Sticky illegal flag; a new error beats a same-cycle clear
   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         ill_r    <= 1'b0;
         err_op_r <= 4'h0;
      end
      else if (take && !legal)
      begin
         ill_r    <= 1'b1;
         err_op_r <= CMD_OP;
      end
      else if (REG_WR && (REG_ADDR == `REG_STATUS) && REG_WDATA[`STAT_ILL_BIT])
      begin
         ill_r <= 1'b0;
      end
   end

   // Read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         REG_RDATA <= 32'h0000_0000;
      end
      else if (REG_RD)
      begin
         unique case (REG_ADDR)
            `REG_CTRL:     REG_RDATA <= 32'(ctrl_vmw_r);
            `REG_STATUS:   REG_RDATA <= 32'({(state_r == ST_WAIT), ill_r});
            `REG_ERR_OP:   REG_RDATA <= 32'(err_op_r);
            `REG_INFLIGHT: REG_RDATA <= 32'({cnt_r[1], cnt_r[0]});
            `REG_CFG_MAP:  REG_RDATA <= 32'(cfg_valid_r);
            `REG_TLB_MAP:  REG_RDATA <= 32'(tif.valid_map);
            `REG_CAPS:     REG_RDATA <= 32'({WIDE_VMID, WIDE_ASID});
            default:       REG_RDATA <= 32'h0000_0000;
         endcase
      end
      else
      begin
         REG_RDATA <= 32'h0000_0000;
      end
   end

endmodule
`default_nettype wire

// file: hw/inval_pkg.sv
// Purpose: Types shared by the invalidation engine and its translation store
// Assumes: Nothing beyond the tool's SystemVerilog support
// Notes:   Opcode codes are local to this engine's command port
package inval_pkg;

   // Commands accepted on the command port
   typedef enum logic [3:0] {
      OP_CFG_EVERY  = 4'h1,
      OP_STE        = 4'h2,
      OP_STE_RANGE  = 4'h3,
      OP_CD         = 4'h4,
      OP_CD_EVERY   = 4'h5,
      OP_TLB_ALL    = 4'h6,
      OP_TLB_VMID   = 4'h7,
      OP_TLB_ASID   = 4'h8,
      OP_TLB_VA     = 4'h9,
      OP_SYNC       = 4'hA
   } cmd_op_t;

   // Kinds of cached configuration structure
   typedef enum logic [2:0] {
      KIND_STE  = 3'h0,
      KIND_FIRST_LEVEL_STREAM_DESCRIPTOR = 3'h1,
      KIND_CD   = 3'h2,
      KIND_FIRST_LEVEL_CONTEXT_DESCRIPTOR = 3'h3,
      KIND_VMS  = 3'h4
   } cfg_kind_t;

   // Matching scope of a translation-cache invalidation
   typedef enum logic [1:0] {
      TM_ALL  = 2'h0,
      TM_VMID = 2'h1,
      TM_ASID = 2'h3,
      TM_VA   = 2'h2
   } tlb_mode_t;

   // Command sequencer
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_WAIT = 1'b1
   } seq_state_t;

endpackage

// file: hw/tlb_if.sv
// Purpose: Carries invalidate and fill traffic to the translation store
// Assumes: Both ends on the same clock
// Notes:   Invalidate and fill never coincide in ST_IDLE, where the sequencer holds commands off during fills; ST_WAIT does not
`timescale 1ns/100ps
`default_nettype none
interface tlb_if
   import inval_pkg::*;
#(
   parameter int ENTRIES = 16,
   parameter int VA_W    = 36
);
   logic                       inv;
   tlb_mode_t                  inv_mode;
   logic                       inv_sec;
   logic [15:0]                inv_vmid;
   logic [15:0]                inv_asid;
   logic [VA_W-1:0]            inv_va;
   logic                       inv_leaf;
   logic                       vmw_en;
   logic                       fill;
   logic [$clog2(ENTRIES)-1:0] fill_idx;
   logic                       fill_sec;
   logic [15:0]                fill_vmid;
   logic [15:0]                fill_asid;
   logic [VA_W-1:0]            fill_va;
   logic [5:0]                 fill_size;
   logic                       fill_leaf;
   logic [ENTRIES-1:0]         valid_map;

   modport ctl (output inv, inv_mode, inv_sec, inv_vmid, inv_asid, inv_va, inv_leaf, vmw_en,
                output fill, fill_idx, fill_sec, fill_vmid, fill_asid, fill_va, fill_size, fill_leaf,
                input  valid_map);
   modport store (input  inv, inv_mode, inv_sec, inv_vmid, inv_asid, inv_va, inv_leaf, vmw_en,
                  input  fill, fill_idx, fill_sec, fill_vmid, fill_asid, fill_va, fill_size, fill_leaf,
                  output valid_map);
endinterface
`default_nettype wire

// file: hw/tlb_store.sv
// Purpose: Translation-cache entries with single-cycle scoped invalidation
// Assumes: Fill and invalidate may coincide in ST_WAIT; the fill then wins for its own entry
// Notes:   Broadcast-exclusion state is not stored; matching never uses it
`timescale 1ns/100ps
`default_nettype none
module tlb_store
   import inval_pkg::*;
#(
   parameter int ENTRIES   = 16,
   parameter int VA_W      = 36,
   parameter int WILD_BITS = 4
)(
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // Control side
   tlb_if.store      tif
);

   logic [ENTRIES-1:0] valid_r;
   logic [ENTRIES-1:0] sec_r;
   logic [ENTRIES-1:0] leaf_r;
   logic [15:0]        vmid_r [ENTRIES];
   logic [15:0]        asid_r [ENTRIES];
   logic [VA_W-1:0]    va_r   [ENTRIES];
   logic [5:0]         size_r [ENTRIES];
   logic [15:0]        vm_mask;

   // Wildcard widens the match by ignoring low VMID bits
   assign vm_mask = tif.vmw_en ? (16'hFFFF << WILD_BITS) : 16'hFFFF;
   assign tif.valid_map = valid_r;

   genvar g;
   generate
      for (g = 0; g < ENTRIES; g++)
      begin : g_ent
         logic vm_eq;
         logic as_eq;
         logic va_eq;
         logic hit;

         // Low address bits inside the entry's own span are ignored
         assign va_eq = (((va_r[g] ^ tif.inv_va) & ({VA_W{1'b1}} << size_r[g])) == '0);
         assign vm_eq = (((vmid_r[g] ^ tif.inv_vmid) & vm_mask) == 16'h0000);
         assign as_eq = (asid_r[g] == tif.inv_asid);

         // Scope of each mode; nothing beyond it is removed
         always_comb
         begin
            hit = 1'b0;
            unique case (tif.inv_mode)
               TM_ALL:  hit = 1'b1;
               TM_VMID: hit = vm_eq;
               TM_ASID: hit = vm_eq && as_eq;
               TM_VA:   hit = vm_eq && as_eq && va_eq && (!tif.inv_leaf || leaf_r[g]);
            endcase
         end

         // Entry storage; removal is one edge, so never half valid
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               valid_r[g] <= 1'b0;
               sec_r[g]   <= 1'b0;
               leaf_r[g]  <= 1'b0;
               vmid_r[g]  <= 16'h0000;
               asid_r[g]  <= 16'h0000;
               va_r[g]    <= '0;
               size_r[g]  <= 6'h00;
            end
            else if (tif.fill && (tif.fill_idx == g))
            begin
               valid_r[g] <= 1'b1;
               sec_r[g]   <= tif.fill_sec;
               leaf_r[g]  <= tif.fill_leaf;
               vmid_r[g]  <= tif.fill_vmid;
               asid_r[g]  <= tif.fill_asid;
               va_r[g]    <= tif.fill_va;
               size_r[g]  <= tif.fill_size;
            end
            else if (tif.inv && valid_r[g] && (sec_r[g] == tif.inv_sec) && hit)
            begin
               valid_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// file: tb/cmd_producer.sv
// Purpose: Software side of the command queue
// Assumes: One command at a time, held until taken
// Notes:   Released VMID and ASID flip so stale values never look valid
`timescale 1ns/100ps
`default_nettype none
module cmd_producer (
   input  wire logic   REF_CLK, CMD_READY,
   output logic        CMD_VALID, CMD_NS_QUEUE, CMD_SEC, CMD_LEAF,
   output logic [3:0]  CMD_OP,
   output logic [4:0]  CMD_RANGE,
   output logic [15:0] CMD_ASID, CMD_VMID,
   output logic [31:0] CMD_SID,
   output logic [35:0] CMD_VA
);
   initial {CMD_VALID, CMD_NS_QUEUE, CMD_SEC, CMD_LEAF, CMD_OP, CMD_RANGE, CMD_ASID, CMD_VMID, CMD_SID, CMD_VA} = 0;
   // Random gap models a slow producer; no resume or stall traffic is issued
   task automatic send(input logic [3:0] o, input logic s, n, input logic [15:0] v);
      // One edge at least between commands, so VALID never moves twice in a step
      repeat (1 + $urandom % 3) @(posedge REF_CLK);
      {CMD_VALID, CMD_OP, CMD_SEC, CMD_NS_QUEUE, CMD_VMID, CMD_ASID} <= {1'b1, o, s, n, v, v};
      // Single-stream invalidate names stream v; elsewhere the stream is noise
      CMD_SID <= (o == 4'h2) ? 32'(v) : $urandom;
      {CMD_RANGE, CMD_VA} <= {5'($urandom), 36'($urandom)};
      // A stuck handshake is left to the bench watchdog
      do @(posedge REF_CLK); while (!CMD_READY);
      {CMD_VALID, CMD_VMID, CMD_ASID} <= {1'b0, ~v, ~v};
   endtask
endmodule
`default_nettype wire

// file: tb/config_and_tlb_invalidation_tb_top.sv
// Purpose: Self-checking bench of the invalidation engine
// Assumes: Default parameters, wide identifiers
// Notes:   Seed fixed for repeatable runs
`timescale 1ns/100ps
`default_nettype none
module config_and_tlb_invalidation_tb_top;
   logic REF_CLK, ARST_N, REG_WR, REG_RD, CMD_VALID, CMD_READY, CMD_NS_QUEUE, CMD_SEC, CMD_LEAF, SYNC_DONE,
         ILLEGAL_CMD, CFG_FILL, CFG_FILL_SEC, TLB_FILL, TLB_FILL_SEC, TLB_FILL_LEAF, XLAT_START, XLAT_DONE,
         XLAT_DONE_EPOCH, XLAT_EPOCH;
   logic [2:0]  CFG_FILL_KIND;
   logic [3:0]  CMD_OP, CFG_FILL_IDX, TLB_FILL_IDX;
   logic [4:0]  CMD_RANGE;
   logic [5:0]  TLB_FILL_SIZE;
   logic [7:0]  REG_ADDR;
   logic [15:0] CMD_ASID, CMD_VMID, TLB_FILL_VMID, TLB_FILL_ASID, vm [4];
   logic [31:0] REG_WDATA, REG_RDATA, CMD_SID, CFG_FILL_SID, rd;
   logic [35:0] CMD_VA, TLB_FILL_VA;
   int err_total, compares, n_ill, n_sync;
   inval_engine u_inval_engine (.*);
   cmd_producer u_cmd_producer (.*);
   initial begin REF_CLK = 0; forever #2.5 REF_CLK = ~REF_CLK; end
   always @(negedge REF_CLK) begin n_ill += ILLEGAL_CMD; n_sync += SYNC_DONE; end
   task automatic chk(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin err_total++; $display("Error %s exp %h got %h", nm, e, g); end
   endtask
   // TLB map after a by-VMID flush: fills 0..3 of another VMID survive
   function automatic logic [31:0] vm_left(input logic [15:0] v0);
      vm_left = 32'h0;
      for (int i = 0; i < 4; i++) vm_left[i] = vm[i] != v0;
   endfunction
   task automatic rreg(input logic [7:0] a);
      {REG_ADDR, REG_RD} <= {a, 1'b1};
      @(posedge REF_CLK) REG_RD <= 0;
      @(negedge REF_CLK) rd = REG_RDATA;
      @(posedge REF_CLK);
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      {REG_ADDR, REG_WDATA, REG_WR} <= {a, d, 1'b1};
      @(posedge REF_CLK) REG_WR <= 0;
   endtask
   task automatic cfill(input int i, input logic s);
      {CFG_FILL, CFG_FILL_IDX, CFG_FILL_SEC} <= {1'b1, 4'(i), s};
      {CFG_FILL_SID, CFG_FILL_KIND} <= {32'(i), 3'($urandom % 5)};
      @(posedge REF_CLK) CFG_FILL <= 0;
      @(posedge REF_CLK);
   endtask
   task automatic tfill(input int i, input logic [15:0] v);
      {TLB_FILL, TLB_FILL_IDX, TLB_FILL_VMID} <= {1'b1, 4'(i), v};
      {TLB_FILL_ASID, TLB_FILL_VA} <= {16'($urandom), 36'($urandom)};
      @(posedge REF_CLK) TLB_FILL <= 0;
      @(posedge REF_CLK);
   endtask
   task automatic end_sim;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Whole run needs a few hundred cycles; 20000 is ample
   initial begin #100us; err_total++; end_sim; end
   initial begin
      {ARST_N, REG_WR, REG_RD, CFG_FILL, TLB_FILL, TLB_FILL_SEC, TLB_FILL_LEAF, XLAT_START, XLAT_DONE} = 9'h004;
      {XLAT_DONE_EPOCH, REG_ADDR, REG_WDATA, CFG_FILL_IDX, CFG_FILL_SEC, CFG_FILL_SID, CFG_FILL_KIND} = 0;
      {TLB_FILL_IDX, TLB_FILL_VMID, TLB_FILL_ASID, TLB_FILL_VA, TLB_FILL_SIZE} = 0;
      void'($urandom(65));
      repeat (10) @(posedge REF_CLK);
      ARST_N <= 1;
      @(posedge REF_CLK);
      rreg(8'h18); chk("caps", 32'h3, rd);
      rreg(8'h40); chk("unmapped", 32'h0, rd);
      wreg(8'h00, 32'h1); rreg(8'h00); chk("ctrl", 32'h1, rd);
      wreg(8'h00, 32'h0);
      // Odd entries secure: a non-secure global invalidate spares them
      for (int i = 0; i < 4; i++) cfill(i, i[0]);
      u_cmd_producer.send(4'h1, 1'b0, 1'b0, 16'h0);
      rreg(8'h10); chk("cfg map", 32'hA, rd);
      u_cmd_producer.send(4'h1, 1'b1, 1'b1, 16'h0);
      rreg(8'h10); chk("cfg map", 32'hA, rd);
      chk("illegal", 32'h1, 32'(n_ill));
      rreg(8'h04); chk("status", 32'h1, rd);
      rreg(8'h08); chk("err op", 32'h1, rd);
      wreg(8'h04, 32'h1); rreg(8'h04); chk("status", 32'h0, rd);
      u_cmd_producer.send(4'h1, 1'b1, 1'b0, 16'h0);
      rreg(8'h10); chk("cfg map", 32'h0, rd);
      // Guest global flush replaced by per-stream flushes of streams 0 and 2
      for (int i = 0; i < 4; i++) cfill(i, 1'b0);
      u_cmd_producer.send(4'h2, 1'b0, 1'b0, 16'h0);
      u_cmd_producer.send(4'h2, 1'b0, 1'b0, 16'h2);
      rreg(8'h10); chk("cfg map", 32'hA, rd);
      // Translation flush follows the config flush, never before it
      repeat (4) begin
         for (int i = 0; i < 4; i++) begin vm[i] = 16'($urandom % 3); tfill(i, vm[i]); end
         u_cmd_producer.send(4'h7, 1'b0, 1'b0, vm[0]);
         rreg(8'h14); chk("tlb map", vm_left(vm[0]), rd);
      end
      u_cmd_producer.send(4'h6, 1'b0, 1'b0, 16'h0);
      rreg(8'h14); chk("tlb map", 32'h0, rd);
      XLAT_START <= 1;
      @(posedge REF_CLK) XLAT_START <= 0;
      fork
         u_cmd_producer.send(4'hA, 1'b0, 1'b0, 16'h0);
         begin
            repeat (6) @(posedge REF_CLK);
            chk("early sync", 32'h0, 32'(n_sync));
            XLAT_DONE <= 1;
            @(posedge REF_CLK) XLAT_DONE <= 0;
         end
      join
      repeat (2) @(posedge REF_CLK);
      chk("sync done", 32'h1, 32'(n_sync));
      chk("epoch", 32'h1, 32'(XLAT_EPOCH));
      end_sim;
   end
endmodule
`default_nettype wire

// file: tb/inval_engine_asserts.sv
// Purpose: Port checks of the invalidation engine
// Assumes: Bound into inval_engine; one clock
// Notes:   Sync and error timing as handed over
`timescale 1ns/100ps
`default_nettype none
module inval_engine_asserts (
   input wire logic       REF_CLK, ARST_N, CMD_VALID, CMD_READY, CMD_NS_QUEUE, CMD_SEC,
   input wire logic       SYNC_DONE, ILLEGAL_CMD, CFG_FILL, TLB_FILL, XLAT_EPOCH,
   input wire logic [3:0] CMD_OP
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!ARST_N);
   // Sync offered, then sync taken
   sequence sync_req;
      CMD_VALID && CMD_OP == 4'hA;
   endsequence
   sequence sync_take;
      CMD_VALID && CMD_READY && CMD_OP == 4'hA;
   endsequence
   ill_raise_a: assert property (CMD_VALID && CMD_READY && CMD_NS_QUEUE && CMD_SEC &&
                                 CMD_OP != 4'hA |=> ILLEGAL_CMD)
      else $error("illegal not raised");
   ill_cause_a: assert property (ILLEGAL_CMD |-> $past(CMD_VALID && CMD_READY))
      else $error("illegal without command");
   done_cause_a: assert property (SYNC_DONE |-> $past(CMD_VALID && CMD_READY && CMD_OP == 4'hA))
      else $error("sync done without take");
   done_pulse_a: assert property (sync_take |=> SYNC_DONE ##1 !SYNC_DONE)
      else $error("sync done not one pulse");
   sync_hold_a: assert property (sync_req ##0 !$past(CMD_VALID && CMD_OP == 4'hA) |-> !CMD_READY)
      else $error("sync taken before epoch flip");
   sync_again_a: assert property (sync_take ##1 sync_req |-> !CMD_READY)
      else $error("second sync taken at once");
   epoch_cause_a: assert property ($changed(XLAT_EPOCH) |-> $past(CMD_VALID && CMD_OP == 4'hA && !CMD_READY))
      else $error("epoch moved without sync");
   fill_stall_a: assert property ((CFG_FILL || TLB_FILL) && CMD_OP != 4'hA |-> !CMD_READY)
      else $error("command taken beside fill");
endmodule
bind inval_engine inval_engine_asserts u_chk (.*);
`default_nettype wire
